//--- inc/serial_unit_pkg.sv
package serial_unit_pkg;
    // Array shape
    localparam int NUM_UNITS   = 2;
    localparam int CH_PER_UNIT = 4;
    localparam int NUM_PINS    = 8;
    localparam int NUM_RX      = 4;

    // Shared register byte offsets
    localparam logic [7:0] OFS_FILTER = 8'h00;
    localparam logic [7:0] OFS_PER    = 8'h04;
    localparam logic [7:0] OFS_ISC    = 8'h08;
    localparam logic [7:0] OFS_PDIR   = 8'h0C;
    localparam logic [7:0] OFS_PLAT   = 8'h10;
    localparam logic [7:0] OFS_PIM    = 8'h14;
    localparam logic [7:0] OFS_POM    = 8'h18;
    localparam logic [7:0] OFS_PMC    = 8'h1C;

    // Per-unit block: unit u sits at UNIT_BASE + u * UNIT_STRIDE
    localparam logic [7:0] UNIT_BASE   = 8'h20;
    localparam logic [7:0] UNIT_STRIDE = 8'h20;
    localparam logic [4:0] UOFS_START  = 5'h00;
    localparam logic [4:0] UOFS_STOP   = 5'h04;
    localparam logic [4:0] UOFS_STAT   = 5'h08;
    localparam logic [4:0] UOFS_OE     = 5'h0C;
    localparam logic [4:0] UOFS_BUF    = 5'h10;

    // Field layouts
    localparam logic [7:0] FILTER_MASK   = 8'h55;
    localparam logic [7:0] PER_MASK      = 8'h0C;
    localparam logic [1:0] ISC_MASK      = 2'h3;
    localparam int         PER_UNIT0_BIT = 2;
    localparam int         BUF_CLK_LSB   = 8;
    localparam int         BUF_DATA_LSB  = 0;

    // Reset values
    localparam logic [7:0]  FILTER_RST = 8'h00;
    localparam logic [7:0]  PER_RST    = 8'h00;
    localparam logic [1:0]  ISC_RST    = 2'h0;
    localparam logic [7:0]  PDIR_RST   = 8'hFF;
    localparam logic [7:0]  PLAT_RST   = 8'h00;
    localparam logic [7:0]  PIM_RST    = 8'h00;
    localparam logic [7:0]  POM_RST    = 8'h00;
    localparam logic [7:0]  PMC_RST    = 8'h00;
    localparam logic [3:0]  CH_RST     = 4'h0;
    localparam logic [15:0] BUF_RST    = 16'h0F0F;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- src/rx_noise_filter.sv
`timescale 1ns/1ps
`default_nettype none
module rx_noise_filter (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic ce,
    input  wire logic filt_en,
    input  wire logic rx_in,
    output var  logic rx_out
);
    logic s1_reg, s1_next;
    logic s2_reg, s2_next;
    logic hold_reg, hold_next;
    logic out_reg, out_next;

    // Sync chain, then sample on the channel clock enable
    always_comb begin
        s1_next   = rx_in;
        s2_next   = s1_reg;
        hold_next = hold_reg;
        out_next  = out_reg;
        if (ce) begin
            hold_next = s2_reg;
            if (!filt_en || s2_reg == hold_reg) begin
                out_next = s2_reg;
            end
        end
    end

    // State registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_reg   <= 1'b1;
            s2_reg   <= 1'b1;
            hold_reg <= 1'b1;
            out_reg  <= 1'b1;
        end else begin
            s1_reg   <= s1_next;
            s2_reg   <= s2_next;
            hold_reg <= hold_next;
            out_reg  <= out_next;
        end
    end

    assign rx_out = out_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_filter_bypass: assert property (
        ce && !filt_en |=> rx_out == $past(s2_reg))
        else $error("unfiltered input not passed through");
    a_filter_match: assert property (
        $changed(rx_out) |-> $past(ce) &&
            ($past(!filt_en) || $past(s2_reg == hold_reg)))
        else $error("filtered input changed without a match");
endmodule // rx_noise_filter
`default_nettype wire

//--- src/serial_unit_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Per-input filter enable bit: 0 filter off, 1 filter on.
// - Filter on: synchronise, then require two equal samples; off: only sync.
// - Open-drain select 1 makes the serial output pin N-channel open-drain.
// - Input buffer select 1 picks the TTL-level input buffer.
// - Stopped channel does no communication; its pins serve as ports.
// - Peripheral enable bit 2 gates unit 0 clock, bit 3 unit 1.
// - Gated unit ignores control writes and reads back defaults.
// - Switch, filter and port registers stay accessible while gated.
// - Stop trigger 1 stops channel; trigger self-clears once status is 0.
// - Enable status is read-only and cleared only by the stop trigger or by clearing the unit's peripheral enable bit.
// - Stopped channel lets software write its clock output level bit.
// - Output-disabled channel lets software write its data level bit.
module serial_unit_ctrl (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output var  logic        arready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready,
    input  wire logic [3:0]  rx_pin,
    output var  logic [3:0]  rx_data,
    input  wire logic [7:0]  eng_data,
    input  wire logic [7:0]  eng_clk,
    output var  logic [7:0]  chan_active,
    output var  logic [7:0]  clk_level,
    output var  logic [7:0]  pin_o,
    output var  logic [7:0]  pin_oe,
    output var  logic [7:0]  ttl_sel,
    output var  logic [1:0]  unit_clk_en,
    output var  logic        rx_to_intp,
    output var  logic        rx_to_timer
);
    localparam int NU = serial_unit_pkg::NUM_UNITS;
    localparam int NC = serial_unit_pkg::CH_PER_UNIT;

    logic [7:0]  filt_reg, filt_next;
    logic [7:0]  per_reg, per_next;
    logic [1:0]  isc_reg, isc_next;
    logic [7:0]  pdir_reg, pdir_next;
    logic [7:0]  plat_reg, plat_next;
    logic [7:0]  pim_reg, pim_next;
    logic [7:0]  pom_reg, pom_next;
    logic [7:0]  pmc_reg, pmc_next;
    logic [3:0]  stop_reg [NU];
    logic [3:0]  stop_next [NU];
    logic [3:0]  stat_reg [NU];
    logic [3:0]  stat_next [NU];
    logic [3:0]  oe_reg [NU];
    logic [3:0]  oe_next [NU];
    logic [15:0] buf_reg [NU];
    logic [15:0] buf_next [NU];
    logic [3:0]  start_wv [NU];
    logic [NU-1:0] stop_wr;
    logic [NU-1:0] gate;

    logic        awready_reg, awready_next;
    logic        bvalid_reg, bvalid_next;
    logic [1:0]  bresp_reg, bresp_next;
    logic        arready_reg, arready_next;
    logic        rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  rresp_reg, rresp_next;
    logic [7:0]  pin_o_reg, pin_o_next;
    logic [7:0]  pin_oe_reg, pin_oe_next;
    logic [7:0]  clk_lvl_reg, clk_lvl_next;
    logic [7:0]  act_reg, act_next;

    logic        wr_fire;
    logic        rd_fire;
    logic [32:0] wr_old;
    logic [32:0] rd_word;
    logic [31:0] lane_mask;
    logic [31:0] wv;

    assign gate[0] = per_reg[serial_unit_pkg::PER_UNIT0_BIT];
    assign gate[1] = per_reg[serial_unit_pkg::PER_UNIT0_BIT + 1];

    // Register read decode; bit 32 flags a mapped address
    function automatic logic [32:0] read_word(input logic [7:0] a);
        logic [31:0] d;
        logic        hit;
        d   = 32'h0000_0000;
        hit = 1'b1;
        case (a)
            serial_unit_pkg::OFS_FILTER: d[7:0] = filt_reg;
            serial_unit_pkg::OFS_PER:    d[7:0] = per_reg;
            serial_unit_pkg::OFS_ISC:    d[1:0] = isc_reg;
            serial_unit_pkg::OFS_PDIR:   d[7:0] = pdir_reg;
            serial_unit_pkg::OFS_PLAT:   d[7:0] = plat_reg;
            serial_unit_pkg::OFS_PIM:    d[7:0] = pim_reg;
            serial_unit_pkg::OFS_POM:    d[7:0] = pom_reg;
            serial_unit_pkg::OFS_PMC:    d[7:0] = pmc_reg;
            default: begin
                hit = 1'b0;
                for (int u = 0; u < NU; u++) begin
                    if (a[7:5] == 3'(u + 1)) begin
                        hit = 1'b1;
                        // Start trigger always reads zero
                        case (a[4:0])
                            serial_unit_pkg::UOFS_START: d = 32'h0000_0000;
                            serial_unit_pkg::UOFS_STOP:  d[3:0] = stop_reg[u];
                            serial_unit_pkg::UOFS_STAT:  d[3:0] = stat_reg[u];
                            serial_unit_pkg::UOFS_OE:    d[3:0] = oe_reg[u];
                            serial_unit_pkg::UOFS_BUF:   d[15:0] = buf_reg[u];
                            default:                     hit = 1'b0;
                        endcase
                    end
                end
            end
        endcase
        return {hit, d};
    endfunction

    // Bus handshakes and merged write value
    assign wr_fire   = awready_reg & awvalid & wvalid;
    assign rd_fire   = arready_reg & arvalid;
    assign wr_old    = read_word(awaddr);
    assign rd_word   = read_word(araddr);
    assign lane_mask = {{8{wstrb[3]}}, {8{wstrb[2]}},
                        {8{wstrb[1]}}, {8{wstrb[0]}}};
    assign wv        = (wr_old[31:0] & ~lane_mask) | (wdata & lane_mask);

    // AXI4-Lite slave: address and data taken together
    always_comb begin
        awready_next = awvalid & wvalid & ~awready_reg & ~bvalid_reg;
        bvalid_next  = bvalid_reg & ~bready;
        bresp_next   = bresp_reg;
        arready_next = arvalid & ~arready_reg & ~rvalid_reg;
        rvalid_next  = rvalid_reg & ~rready;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (wr_fire) begin
            bvalid_next = 1'b1;
            bresp_next  = wr_old[32] ? serial_unit_pkg::RESP_OKAY
                                     : serial_unit_pkg::RESP_SLVERR;
        end
        if (rd_fire) begin
            rvalid_next = 1'b1;
            rdata_next  = rd_word[31:0];
            rresp_next  = rd_word[32] ? serial_unit_pkg::RESP_OKAY
                                      : serial_unit_pkg::RESP_SLVERR;
        end
    end

    // Control register next state
    always_comb begin
        filt_next = filt_reg;
        per_next  = per_reg;
        isc_next  = isc_reg;
        pdir_next = pdir_reg;
        plat_next = plat_reg;
        pim_next  = pim_reg;
        pom_next  = pom_reg;
        pmc_next  = pmc_reg;
        stop_wr   = '0;
        if (wr_fire) begin
            case (awaddr)
                serial_unit_pkg::OFS_FILTER:
                    filt_next = wv[7:0] & serial_unit_pkg::FILTER_MASK;
                serial_unit_pkg::OFS_PER:
                    per_next = wv[7:0] & serial_unit_pkg::PER_MASK;
                serial_unit_pkg::OFS_ISC:
                    isc_next = wv[1:0] & serial_unit_pkg::ISC_MASK;
                serial_unit_pkg::OFS_PDIR: pdir_next = wv[7:0];
                serial_unit_pkg::OFS_PLAT: plat_next = wv[7:0];
                serial_unit_pkg::OFS_PIM:  pim_next  = wv[7:0];
                serial_unit_pkg::OFS_POM:  pom_next  = wv[7:0];
                serial_unit_pkg::OFS_PMC:  pmc_next  = wv[7:0];
                default: ;
            endcase
        end
        for (int u = 0; u < NU; u++) begin
            start_wv[u] = 4'h0;
            // trigger self-clears once status is low
            stop_next[u] = stop_reg[u] & stat_reg[u];
            oe_next[u]   = oe_reg[u];
            buf_next[u]  = buf_reg[u];
            if (wr_fire && gate[u] && awaddr[7:5] == 3'(u + 1)) begin
                case (awaddr[4:0])
                    serial_unit_pkg::UOFS_START: start_wv[u] = wv[3:0];
                    serial_unit_pkg::UOFS_STOP: begin
                        stop_next[u] = wv[3:0];
                        stop_wr[u]   = 1'b1;
                    end
                    serial_unit_pkg::UOFS_OE: oe_next[u] = wv[3:0];
                    serial_unit_pkg::UOFS_BUF: begin
                        for (int c = 0; c < NC; c++) begin
                            if (!stat_reg[u][c]) begin
                                buf_next[u][serial_unit_pkg::BUF_CLK_LSB + c] =
                                    wv[serial_unit_pkg::BUF_CLK_LSB + c];
                            end
                            if (!oe_reg[u][c]) begin
                                buf_next[u][serial_unit_pkg::BUF_DATA_LSB + c] =
                                    wv[serial_unit_pkg::BUF_DATA_LSB + c];
                            end
                        end
                    end
                    default: ;
                endcase
            end
            // start sets, and wins over stop
            stat_next[u] = (stat_reg[u] & ~stop_reg[u]) | start_wv[u];
            if (!gate[u]) begin
                stop_next[u] = serial_unit_pkg::CH_RST;
                stat_next[u] = serial_unit_pkg::CH_RST;
                oe_next[u]   = serial_unit_pkg::CH_RST;
                buf_next[u]  = serial_unit_pkg::BUF_RST;
            end
        end
    end

    // Pin drive per channel
    always_comb begin
        for (int i = 0; i < serial_unit_pkg::NUM_PINS; i++) begin
            logic act;
            logic lvl;
            logic v;
            act = gate[i / NC] & stat_reg[i / NC][i % NC];
            lvl = (act & oe_reg[i / NC][i % NC]) ? eng_data[i]
                : buf_reg[i / NC][serial_unit_pkg::BUF_DATA_LSB + i % NC];
            v   = plat_reg[i] & lvl;
            // engine reaches pins only while running
            act_next[i] = act;
            clk_lvl_next[i] = act ? eng_clk[i]
                : buf_reg[i / NC][serial_unit_pkg::BUF_CLK_LSB + i % NC];
            pin_o_next[i]  = v & ~pom_reg[i];
            pin_oe_next[i] = ~pdir_reg[i] & ~pmc_reg[i] & ~(pom_reg[i] & v);
        end
    end

    // State registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            filt_reg    <= serial_unit_pkg::FILTER_RST;
            per_reg     <= serial_unit_pkg::PER_RST;
            isc_reg     <= serial_unit_pkg::ISC_RST;
            pdir_reg    <= serial_unit_pkg::PDIR_RST;
            plat_reg    <= serial_unit_pkg::PLAT_RST;
            pim_reg     <= serial_unit_pkg::PIM_RST;
            pom_reg     <= serial_unit_pkg::POM_RST;
            pmc_reg     <= serial_unit_pkg::PMC_RST;
            for (int u = 0; u < NU; u++) begin
                stop_reg[u] <= serial_unit_pkg::CH_RST;
                stat_reg[u] <= serial_unit_pkg::CH_RST;
                oe_reg[u]   <= serial_unit_pkg::CH_RST;
                buf_reg[u]  <= serial_unit_pkg::BUF_RST;
            end
            awready_reg <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= serial_unit_pkg::RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= serial_unit_pkg::RESP_OKAY;
            pin_o_reg   <= 8'h00;
            pin_oe_reg  <= 8'h00;
            clk_lvl_reg <= 8'h00;
            act_reg     <= 8'h00;
        end else begin
            filt_reg    <= filt_next;
            per_reg     <= per_next;
            isc_reg     <= isc_next;
            pdir_reg    <= pdir_next;
            plat_reg    <= plat_next;
            pim_reg     <= pim_next;
            pom_reg     <= pom_next;
            pmc_reg     <= pmc_next;
            stop_reg    <= stop_next;
            stat_reg    <= stat_next;
            oe_reg      <= oe_next;
            buf_reg     <= buf_next;
            awready_reg <= awready_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            pin_o_reg   <= pin_o_next;
            pin_oe_reg  <= pin_oe_next;
            clk_lvl_reg <= clk_lvl_next;
            act_reg     <= act_next;
        end
    end

    // Receive filters, two per unit
    for (genvar r = 0; r < serial_unit_pkg::NUM_RX; r++) begin : g_rx
        rx_noise_filter u_filt (
            .clk     (clk),
            .rstn    (rstn),
            .ce      (gate[r / 2]),
            .filt_en (filt_reg[2 * r]),
            .rx_in   (rx_pin[r]),
            .rx_out  (rx_data[r])
        );
    end

    // Outputs
    assign awready     = awready_reg;
    assign wready      = awready_reg;
    assign bvalid      = bvalid_reg;
    assign bresp       = bresp_reg;
    assign arready     = arready_reg;
    assign rvalid      = rvalid_reg;
    assign rdata       = rdata_reg;
    assign rresp       = rresp_reg;
    assign pin_o       = pin_o_reg;
    assign pin_oe      = pin_oe_reg;
    assign clk_level   = clk_lvl_reg;
    assign chan_active = act_reg;
    assign ttl_sel     = pim_reg;
    assign unit_clk_en = per_reg[3:2];
    assign rx_to_intp  = isc_reg[0];
    assign rx_to_timer = isc_reg[1];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_stop_pending;
        (stop_reg[0] & stat_reg[0]) != 4'h0 && start_wv[0] == 4'h0;
    endsequence

    a_stop_clears: assert property (
        s_stop_pending |=> (stat_reg[0] & $past(stop_reg[0])) == 4'h0)
        else $error("stop trigger did not clear status");
    a_trig_release: assert property (
        stat_reg[0] == 4'h0 && !stop_wr[0] |=> stop_reg[0] == 4'h0)
        else $error("stop trigger did not self-clear");
    a_start_sets: assert property (
        gate[0] && start_wv[0] != 4'h0 |=>
            (stat_reg[0] & $past(start_wv[0])) == $past(start_wv[0]))
        else $error("start trigger did not set status");
    a_status_holds: assert property (
        gate[0] && stop_reg[0] == 4'h0 |=>
            (stat_reg[0] & $past(stat_reg[0])) == $past(stat_reg[0]))
        else $error("status fell without stop trigger");
    a_gate_defaults: assert property (
        !gate[0] |=> stat_reg[0] == 4'h0 && oe_reg[0] == 4'h0 &&
            buf_reg[0] == serial_unit_pkg::BUF_RST)
        else $error("gated unit left non-default state");
    a_ungated_write: assert property (
        wr_fire && wstrb[0] && awaddr == serial_unit_pkg::OFS_FILTER |=>
            filt_reg == ($past(wdata[7:0]) & serial_unit_pkg::FILTER_MASK))
        else $error("filter enable write lost");
    a_gate_bits: assert property (
        wr_fire && wstrb[0] && awaddr == serial_unit_pkg::OFS_PER |=>
            unit_clk_en == $past(wdata[3:2]))
        else $error("unit clock gate not updated");
    a_open_drain: assert property (
        $stable(pom_reg) |-> (pin_oe & pin_o & pom_reg) == 8'h00)
        else $error("open-drain pin driven high");
    a_ttl_select: assert property (
        wr_fire && wstrb[0] && awaddr == serial_unit_pkg::OFS_PIM |=>
            ttl_sel == $past(wdata[7:0]))
        else $error("input buffer select not updated");
    a_data_level: assert property (
        wr_fire && wstrb[0] && gate[0] && oe_reg[0] == 4'h0 &&
            awaddr == serial_unit_pkg::UNIT_BASE + 8'(serial_unit_pkg::UOFS_BUF)
            |=> buf_reg[0][3:0] == $past(wdata[3:0]))
        else $error("data level write lost");
    a_stopped_port: assert property (
        !gate[0] |=> chan_active[3:0] == 4'h0)
        else $error("gated channel still active");
endmodule // serial_unit_ctrl
`default_nettype wire

//--- tb/serial_unit_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module serial_unit_ctrl_bench;
    localparam logic [7:0] U0 = serial_unit_pkg::UNIT_BASE;
    localparam logic [7:0] U1 = U0 + serial_unit_pkg::UNIT_STRIDE;
    logic        clk, rstn, awvalid, wvalid, arvalid, bready, rready;
    logic        awready, wready, bvalid, arready, rvalid, rx_to_intp;
    logic        rx_to_timer;
    logic [7:0]  awaddr, araddr, eng_data, eng_clk, chan_active, clk_level;
    logic [7:0]  pin_o, pin_oe, ttl_sel;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, rx_pin, rx_data;
    logic [1:0]  bresp, rresp, unit_clk_en, rsp;
    logic [31:0] rd;
    int          bad_count, total_checks;
    serial_unit_ctrl dut (.clk(clk), .rstn(rstn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .rx_pin(rx_pin), .rx_data(rx_data),
        .eng_data(eng_data), .eng_clk(eng_clk), .chan_active(chan_active),
        .clk_level(clk_level), .pin_o(pin_o), .pin_oe(pin_oe),
        .ttl_sel(ttl_sel), .unit_clk_en(unit_clk_en),
        .rx_to_intp(rx_to_intp), .rx_to_timer(rx_to_timer));
    // Clock generation
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Compare tasks, one per result kind
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t response %h expected %h", $time, got, exp);
        end
    endtask
    // AXI4-Lite write: address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // Each channel released at its own handshake edge
        do begin
            @(posedge clk);
            if (awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (wready === 1'b1) begin
                wvalid <= 1'b0;
                w_done = 1'b1;
            end
        end while (!(aw_done && w_done));
        do @(posedge clk); while (bvalid !== 1'b1);
        rsp = bresp;
    endtask
    // AXI4-Lite read
    task automatic rdt(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rd = rdata;
        rsp = rresp;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rdt(a);
        chk(rd, exp);
    endtask
    // Reset values, unmapped read, gated unit writes
    task automatic t_reset_gate;
        rchk(serial_unit_pkg::OFS_PDIR, 32'h000000FF);
        rchk(U1 + 8'h10, 32'h00000F0F);
        rdt(8'hFC);
        chk_resp(rsp, serial_unit_pkg::RESP_SLVERR);
        wr(U1 + 8'h0C, 32'h0000000F);
        chk_resp(rsp, serial_unit_pkg::RESP_OKAY);
        rchk(U1 + 8'h0C, 32'h00000000);
        wr(serial_unit_pkg::OFS_FILTER, 32'h00000055);
        rchk(serial_unit_pkg::OFS_FILTER, 32'h00000055);
        wr(serial_unit_pkg::OFS_ISC, 32'h00000003);
        chk(32'({rx_to_timer, rx_to_intp}), 32'h00000003);
        $display("test reset_gate done");
    endtask
    // Unit enable, start, stop and buffer write locks
    task automatic t_stop;
        wr(serial_unit_pkg::OFS_PER, 32'h00000004);
        chk(32'(unit_clk_en), 32'h00000001);
        wr(U0 + 8'h00, 32'h00000001);
        rchk(U0 + 8'h08, 32'h00000001);
        chk(32'(chan_active), 32'h00000001);
        wr(U0 + 8'h08, 32'h00000000);
        rchk(U0 + 8'h08, 32'h00000001);
        wr(U0 + 8'h10, 32'h00000000);
        rchk(U0 + 8'h10, 32'h00000100);
        chk(32'(clk_level[0]), 32'h00000000);
        wr(U0 + 8'h04, 32'h00000001);
        rchk(U0 + 8'h08, 32'h00000000);
        rchk(U0 + 8'h04, 32'h00000000);
        chk(32'(clk_level[0]), 32'h00000001);
        chk(32'(chan_active), 32'h00000000);
        // Stopped and output-disabled: both level bits now writable
        wr(U0 + 8'h10, 32'h00000F0F);
        rchk(U0 + 8'h10, 32'h00000F0F);
        $display("test stop done");
    endtask
    // Glitch on both receive inputs, filter only on input 0
    task automatic t_filter;
        logic low0, low1;
        low0 = 1'b0;
        low1 = 1'b0;
        wr(serial_unit_pkg::OFS_FILTER, 32'h00000001);
        rx_pin <= 4'hC;
        @(posedge clk);
        rx_pin <= 4'hF;
        repeat (8) begin
            @(posedge clk);
            low0 = low0 | (rx_data[0] === 1'b0);
            low1 = low1 | (rx_data[1] === 1'b0);
        end
        chk(32'({low1, low0}), 32'h00000002);
        rx_pin <= 4'hE;
        repeat (8) @(posedge clk);
        chk(32'(rx_data[0]), 32'h00000000);
        $display("test filter done");
    endtask
    // Port pin drive, open-drain and buffer select
    task automatic t_pins;
        wr(serial_unit_pkg::OFS_PDIR, 32'h00000000);
        wr(serial_unit_pkg::OFS_PLAT, 32'h000000FF);
        wr(serial_unit_pkg::OFS_POM, 32'h00000010);
        wr(serial_unit_pkg::OFS_PIM, 32'h000000A5);
        repeat (2) @(posedge clk);
        chk(32'(pin_oe[5:4]), 32'h00000002);
        chk(32'(pin_o[5:4]), 32'h00000002);
        chk(32'(ttl_sel), 32'h000000A5);
        // Back to input use: every pin driver released
        wr(serial_unit_pkg::OFS_PDIR, 32'h000000FF);
        repeat (2) @(posedge clk);
        chk(32'(pin_oe), 32'h00000000);
        $display("test pins done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run();
    end
    // Main sequence
    initial begin
        bad_count = 0;
        total_checks = 0;
        rstn = 1'b0;
        {awvalid, wvalid, arvalid} = 3'h0;
        {bready, rready} = 2'h3;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        rx_pin = 4'hF;
        eng_data = 8'hFF;
        eng_clk = 8'h00;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset_gate();
        t_stop();
        t_filter();
        t_pins();
        complete_run();
    end
endmodule // serial_unit_ctrl_bench
`default_nettype wire
